// ==== logic/cbst_pkg.sv ====
// shared constants and types of the cell-balance status timer
package cbst_pkg;
    // clock and tick timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1000;
    localparam int unsigned CYCLES_PER_TICK = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned MIN_PER_HOUR = 60;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h080;
    localparam logic [9:0] IDX_PROGRESS = 10'h081;
    localparam logic [9:0] IDX_UVSTAT = 10'h082;
    localparam logic [9:0] IDX_EXPIRY = 10'h090;
    localparam logic [9:0] IDX_SWITCH = 10'h091;
    localparam int unsigned IDX_W = 10;

    // field positions
    localparam int unsigned ACT_LSB = 14;
    localparam int unsigned UNIT_LSB = 12;
    localparam int unsigned CNTR_LSB = 10;
    localparam int unsigned MODE_LSB = 11;
    localparam int unsigned HOLD_LSB = 8;
    localparam int unsigned NUM_CELLS = 14;
    localparam int unsigned TIMER_W = 10;

    // field values
    localparam logic [1:0] ACT_DISABLED = 2'h0;
    localparam logic [1:0] ACT_RUNNING = 2'h1;
    localparam logic [1:0] ACT_DONE = 2'h2;
    localparam logic [1:0] ACT_HALTED = 2'h3;
    localparam logic [1:0] UNIT_NONE = 2'h0;
    localparam logic [1:0] UNIT_SEC = 2'h1;
    localparam logic [1:0] UNIT_MIN = 2'h2;
    localparam logic [1:0] UNIT_HOUR = 2'h3;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EMERGENCY = 3'h1;
    localparam logic [1:0] HOLD_NONE = 2'h0;
    localparam logic [1:0] HOLD_EXTEND = 2'h2;
    localparam logic [1:0] HOLD_FOREVER = 2'h3;
    localparam logic [9:0] EXPIRY_INFINITE = 10'h3ff;

    // hold extension lengths in minutes, per timer unit
    localparam logic [11:0] EXT_MIN_SEC_UNIT = 12'h005;
    localparam logic [11:0] EXT_MIN_MIN_UNIT = 12'h040;
    localparam logic [11:0] EXT_MIN_HOUR_UNIT = 12'hf00;

    // reset values
    localparam logic [9:0] EXPIRY_RESET = 10'h000;
    localparam logic [13:0] SWITCH_RESET = 14'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_DONE,
        ST_HALT
    } cbst_state_t;
endpackage

// ==== logic/cbst_pulse_div.sv ====
// pulse divider: one output pulse for every DIV input pulses
`timescale 1ns/10ps
module cbst_pulse_div #(
    parameter int unsigned DIV = 60
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic inPulse,
    // output
    output logic outPulse
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    if (DIV < 2) begin : g_check
        $error("cbst_pulse_div: DIV must be at least 2");
    end

    logic [CW-1:0] count_r;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count_r <= '0;
        end else if (inPulse) begin
            count_r <= (count_r == LAST) ? '0 : count_r + 1'b1;
        end
    end

    assign outPulse = inPulse && (count_r == LAST) && !clear;
endmodule

// ==== logic/cbst_ahb_if.sv ====
// ahb-lite slave front end: decode, write strobe, registered read data
`timescale 1ns/10ps
module cbst_ahb_if import cbst_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output logic wrStrobe,
    output logic [IDX_W-1:0] wrIndex,
    output logic [15:0] wrData,
    output logic [IDX_W-1:0] rdIndex,
    input wire logic rdHit,
    input wire logic [15:0] rdValue
);
    logic addrPhase;
    logic wordAligned;
    logic wrPend_r;
    logic [IDX_W-1:0] wrIndex_r;
    logic [31:0] hrdata_r;

    assign wordAligned = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
    assign addrPhase = hsel && htrans[1] && hready && wordAligned;
    assign rdIndex = haddr[11:2];

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrIndex_r <= '0;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrIndex_r <= haddr[11:2];
        end
    end

    // unmapped or unaligned reads return zero
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_r <= 32'h00000000;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata_r <= (wordAligned && rdHit) ? {16'h0000, rdValue} : 32'h00000000;
        end
    end

    assign wrStrobe = wrPend_r;
    assign wrIndex = wrIndex_r;
    assign wrData = hwdata[15:0];
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// ==== logic/cbst_top.sv ====
// cell-balance status timer: control, progress and undervoltage status over ahb-lite
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
module cbst_top import cbst_pkg::*; #(
    parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_TICK
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // measurement results, one bit per cell, and the undervoltage check enable
    input wire logic [NUM_CELLS-1:0] cellBelowThreshold,
    input wire logic [NUM_CELLS-1:0] cellCheckUnsupported,
    input wire logic uvCheckEnable,
    // exit alerts
    input wire logic thermalExitAlert,
    input wire logic timeoutExitAlert,
    input wire logic calibrationFaultAlert,
    // shutdown hold
    output logic shutdownLine
);
    if (CYCLES_PER_SEC < 2) begin : g_check
        $error("cbst_top: CYCLES_PER_SEC must be at least 2");
    end

    logic wrStrobe;
    logic [IDX_W-1:0] wrIndex;
    logic [15:0] wrData;
    logic [IDX_W-1:0] rdIndex;
    logic rdHit;
    logic [15:0] rdValue;

    cbst_ahb_if u_bus (
        .clk(clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wrStrobe(wrStrobe),
        .wrIndex(wrIndex),
        .wrData(wrData),
        .rdIndex(rdIndex),
        .rdHit(rdHit),
        .rdValue(rdValue)
    );

    // software-written settings
    logic [2:0] balanceModeSelect_r;
    logic [1:0] shutdownHoldSetting_r;
    logic [TIMER_W-1:0] balanceExpirySetting_r;
    logic [NUM_CELLS-1:0] cellSwitchEnable_r;
    logic ctrlWrite;
    logic balanceLaunch;
    logic balanceDisable;
    logic [2:0] wrMode;

    assign wrMode = wrData[MODE_LSB +: 3];
    assign ctrlWrite = wrStrobe && (wrIndex == IDX_CTRL);
    assign balanceLaunch = ctrlWrite && (wrMode != MODE_OFF);
    assign balanceDisable = ctrlWrite && (wrMode == MODE_OFF);

    always_ff @(posedge clk) begin
        if (rst) begin
            balanceModeSelect_r <= MODE_OFF;
            shutdownHoldSetting_r <= HOLD_NONE;
        end else if (ctrlWrite) begin
            balanceModeSelect_r <= wrMode;
            shutdownHoldSetting_r <= wrData[HOLD_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            balanceExpirySetting_r <= EXPIRY_RESET;
        end else if (wrStrobe && (wrIndex == IDX_EXPIRY)) begin
            balanceExpirySetting_r <= wrData[TIMER_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cellSwitchEnable_r <= SWITCH_RESET;
        end else if (wrStrobe && (wrIndex == IDX_SWITCH)) begin
            cellSwitchEnable_r <= wrData[NUM_CELLS-1:0];
        end
    end

    // second, minute and hour ticks, realigned at launch
    logic secTick;
    logic minTick;
    logic hourTick;

    cbst_pulse_div #(.DIV(CYCLES_PER_SEC)) u_sec (
        .clk(clk),
        .rst(rst),
        .clear(ctrlWrite),
        .inPulse(1'b1),
        .outPulse(secTick)
    );

    cbst_pulse_div #(.DIV(SEC_PER_MIN)) u_min (
        .clk(clk),
        .rst(rst),
        .clear(ctrlWrite),
        .inPulse(secTick),
        .outPulse(minTick)
    );

    cbst_pulse_div #(.DIV(MIN_PER_HOUR)) u_hour (
        .clk(clk),
        .rst(rst),
        .clear(ctrlWrite),
        .inPulse(minTick),
        .outPulse(hourTick)
    );

    logic [1:0] launchUnit;
    always_comb begin
        case (wrMode)
            MODE_OFF: launchUnit = UNIT_NONE;
            MODE_EMERGENCY: launchUnit = UNIT_HOUR;
            default: launchUnit = wrMode[0] ? UNIT_MIN : UNIT_SEC;
        endcase
    end

    logic [1:0] timerUnit_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            timerUnit_r <= UNIT_NONE;
        end else if (ctrlWrite) begin
            timerUnit_r <= launchUnit;
        end
    end

    logic unitTick;
    always_comb begin
        case (timerUnit_r)
            UNIT_SEC: unitTick = secTick;
            UNIT_MIN: unitTick = minTick;
            UNIT_HOUR: unitTick = hourTick;
            default: unitTick = 1'b0;
        endcase
    end

    // operation state
    cbst_state_t state_r;
    cbst_state_t stateNxt;
    logic [TIMER_W-1:0] balanceElapsedTimer_r;
    logic [NUM_CELLS-1:0] perCellUndervoltageFlags_r;
    logic autoMode;
    logic expiryReached;
    logic allCellsEnded;
    logic haltNow;
    logic endNow;

    assign autoMode = balanceModeSelect_r[2];
    assign haltNow = thermalExitAlert || timeoutExitAlert || calibrationFaultAlert;
    // infinite expiry never ends the operation
    assign expiryReached = (balanceExpirySetting_r != EXPIRY_INFINITE) && unitTick
        && ((balanceElapsedTimer_r + 1'b1) >= balanceExpirySetting_r);
    assign allCellsEnded = autoMode && (cellSwitchEnable_r != '0)
        && ((perCellUndervoltageFlags_r & cellSwitchEnable_r) == cellSwitchEnable_r);

    always_comb begin
        stateNxt = state_r;
        case (state_r)
            ST_ACTIVE: begin
                if (haltNow) begin
                    stateNxt = ST_HALT;
                end else if (expiryReached || allCellsEnded) begin
                    stateNxt = ST_DONE;
                end
            end
            ST_IDLE, ST_DONE, ST_HALT: stateNxt = state_r;
            default: stateNxt = ST_IDLE;
        endcase
        // only disable or launch leaves a final state
        if (balanceDisable) begin
            stateNxt = ST_IDLE;
        end else if (balanceLaunch) begin
            stateNxt = ST_ACTIVE;
        end
    end

    assign endNow = (state_r == ST_ACTIVE) && ((stateNxt == ST_DONE) || (stateNxt == ST_HALT));

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= stateNxt;
        end
    end

    logic [1:0] activityCode;
    always_comb begin
        case (state_r)
            ST_ACTIVE: activityCode = ACT_RUNNING;
            ST_DONE: activityCode = ACT_DONE;
            ST_HALT: activityCode = ACT_HALTED;
            default: activityCode = ACT_DISABLED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || ctrlWrite) begin
            balanceElapsedTimer_r <= '0;
        // counts in the selected unit, wraps
        end else if ((state_r == ST_ACTIVE) && unitTick) begin
            balanceElapsedTimer_r <= balanceElapsedTimer_r + 1'b1;
        end
    end

    // 1 Hz counter whenever a mode is selected
    logic [1:0] oneHzActivityCounter_r;
    always_ff @(posedge clk) begin
        if (rst || ctrlWrite) begin
            oneHzActivityCounter_r <= 2'h0;
        // also runs in hold extension; ignores expiry
        end else if ((balanceModeSelect_r != MODE_OFF) && secTick) begin
            oneHzActivityCounter_r <= oneHzActivityCounter_r + 1'b1;
        end
    end

    // flag cells below threshold; and unsupported cells
    logic [NUM_CELLS-1:0] flagSet;
    assign flagSet = ((state_r == ST_ACTIVE) && autoMode && uvCheckEnable && !balanceDisable)
        ? ((cellBelowThreshold | cellCheckUnsupported) & cellSwitchEnable_r) : '0;

    // cleared only on control write; cell n at bit n-1
    always_ff @(posedge clk) begin
        if (rst) begin
            perCellUndervoltageFlags_r <= '0;
        end else begin
            perCellUndervoltageFlags_r <= (ctrlWrite ? '0 : perCellUndervoltageFlags_r) | flagSet;
        end
    end

    // hold extension in minute ticks; one spare tick keeps it from ending early
    logic [11:0] extLeft_r;
    logic [11:0] extLength;
    logic extActive;

    always_comb begin
        case (timerUnit_r)
            UNIT_MIN: extLength = EXT_MIN_MIN_UNIT;
            UNIT_HOUR: extLength = EXT_MIN_HOUR_UNIT;
            default: extLength = EXT_MIN_SEC_UNIT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || ctrlWrite) begin
            extLeft_r <= 12'h000;
        end else if (endNow) begin
            extLeft_r <= extLength + 12'h001;
        end else if (minTick && (extLeft_r != 12'h000)) begin
            extLeft_r <= extLeft_r - 1'b1;
        end
    end

    assign extActive = ((state_r == ST_DONE) || (state_r == ST_HALT))
        && ((shutdownHoldSetting_r == HOLD_FOREVER)
        || ((shutdownHoldSetting_r == HOLD_EXTEND) && (extLeft_r != 12'h000)));

    // shutdown line held during run and extension
    always_ff @(posedge clk) begin
        if (rst) begin
            shutdownLine <= 1'b0;
        end else begin
            shutdownLine <= ((stateNxt == ST_ACTIVE) && (shutdownHoldSetting_r != HOLD_NONE))
                || extActive;
        end
    end

    logic [TIMER_W-1:0] timerView;
    assign timerView = extActive ? balanceExpirySetting_r : balanceElapsedTimer_r;

    // read mux; status writes decode to nothing
    always_comb begin
        rdHit = 1'b1;
        case (rdIndex)
            IDX_CTRL: rdValue = {activityCode, balanceModeSelect_r, 1'b0, shutdownHoldSetting_r, 8'h00};
            IDX_PROGRESS: rdValue = {activityCode, timerUnit_r, oneHzActivityCounter_r, timerView};
            IDX_UVSTAT: rdValue = {activityCode, perCellUndervoltageFlags_r};
            IDX_EXPIRY: rdValue = {6'h00, balanceExpirySetting_r};
            IDX_SWITCH: rdValue = {2'h0, cellSwitchEnable_r};
            default: begin
                rdHit = 1'b0;
                rdValue = 16'h0000;
            end
        endcase
    end
endmodule

// ==== tb/cbst_top_properties.sv ====
// assertion checker bound to the cell-balance status timer top
`timescale 1ns/10ps
module cbst_top_properties import cbst_pkg::*; #(
    parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_TICK
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // cell results and alerts
    input wire logic [NUM_CELLS-1:0] cellBelowThreshold,
    input wire logic [NUM_CELLS-1:0] cellCheckUnsupported,
    input wire logic uvCheckEnable,
    input wire logic thermalExitAlert,
    input wire logic timeoutExitAlert,
    input wire logic calibrationFaultAlert,
    // shutdown hold
    input wire logic shutdownLine
);
    logic rdPh_r, wdPh_r, ctlPh_r;
    logic [31:0] adr_r;
    wire progRd = rdPh_r && wdPh_r && adr_r == 32'h204;
    wire uvRd = rdPh_r && wdPh_r && adr_r == 32'h208;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // remembers what the current data phase belongs to
    always_ff @(posedge clk) begin
        if (rst) begin
            rdPh_r <= 1'b0;
            ctlPh_r <= 1'b0;
        end else if (hready) begin
            rdPh_r <= hsel && htrans[1] && !hwrite;
            ctlPh_r <= hsel && htrans[1] && hwrite && hsize == 3'h2 && haddr == 32'h200;
        end
    end
    always_ff @(posedge clk) begin
        if (hready) begin
            wdPh_r <= hsize == 3'h2;
            adr_r <= haddr;
        end
    end
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
    property p_rst; $fell(rst) |-> hrdata == 32'h0 && !shutdownLine; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_upper; rdPh_r |-> hrdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_unmap;
        rdPh_r && !(wdPh_r && adr_r inside {32'h200, 32'h204, 32'h208, 32'h240, 32'h244}) |-> hrdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_poff; progRd && hrdata[15:14] == ACT_DISABLED |-> hrdata[13:0] == 14'h0; endproperty
    a_poff: assert property (p_poff) else $error("progress fields set while disabled");
    property p_unit; progRd && hrdata[15:14] != ACT_DISABLED |-> hrdata[13:12] != UNIT_NONE; endproperty
    a_unit: assert property (p_unit) else $error("no timer unit while enabled");
    property p_uvoff; uvRd && hrdata[15:14] == ACT_DISABLED |-> hrdata[13:0] == 14'h0; endproperty
    a_uvoff: assert property (p_uvoff) else $error("cell flags set while disabled");
    property p_hold_on;
        ctlPh_r && hwdata[13:11] != MODE_OFF && hwdata[9:8] == HOLD_FOREVER |-> ##[1:4] shutdownLine;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("shutdown line not raised");
    property p_hold_off; ctlPh_r && hwdata[9:8] == HOLD_NONE |-> ##3 !shutdownLine; endproperty
    a_hold_off: assert property (p_hold_off) else $error("shutdown line held without hold");
endmodule

bind cbst_top cbst_top_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_props (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .cellBelowThreshold, .cellCheckUnsupported, .uvCheckEnable, .thermalExitAlert, .timeoutExitAlert,
    .calibrationFaultAlert, .shutdownLine
);

// ==== tb/testbench.sv ====
// self-checking bench for the cell-balance status timer
`timescale 1ns/10ps
module testbench import cbst_pkg::*; ;
    localparam int CPS = 20;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, uvCheckEnable = 1'b0;
    logic thermalExitAlert = 1'b0, timeoutExitAlert = 1'b0, calibrationFaultAlert = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [NUM_CELLS-1:0] cellBelowThreshold = 14'h0, cellCheckUnsupported = 14'h0;
    logic hreadyout, hresp, shutdownLine;
    logic [31:0] hrdata, r;
    logic [13:0] sw, bl, f;
    int err_count = 0, comparisons = 0, cyc = 0, t0 = 0, e = 0;
    int offs[$] = '{0, 4, 8, 64, 68};
    cbst_top #(.CYCLES_PER_SEC(CPS)) dut (
        .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .cellBelowThreshold, .cellCheckUnsupported, .uvCheckEnable, .thermalExitAlert,
        .timeoutExitAlert, .calibrationFaultAlert, .shutdownLine
    );
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, 3'h2, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, 3'h2, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic launch(input int m, input int h);
        wr(32'h200, {18'h0, m[2:0], 1'b0, h[1:0], 8'h0});
        t0 = cyc;
    endtask
    // waits until the middle of second s after the last launch
    task automatic upto(input int s);
        while (cyc - t0 < s * CPS + CPS / 2) @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] pv(input int c, input int u, input int n, input int t);
        return {16'h0, c[1:0], u[1:0], n[1:0], t[9:0]};
    endfunction
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(77187));
        do_reset();
        foreach (offs[i]) rdc(32'h200 + offs[i], 32'h0);
        wr(32'h240, 32'h3ff);
        for (int m = 1; m < 8; m++) begin
            launch(m, 0);
            upto(0);
            rdc(32'h204, pv(1, m == 1 ? 3 : m % 2 + 1, 0, 0));
            upto(1);
            rdc(32'h204, pv(1, m == 1 ? 3 : m % 2 + 1, 1, m % 2 == 0));
        end
        e = 3 + $urandom % 4;
        wr(32'h240, e);
        launch(2, 3);
        for (int s = 0; s < e + 3; s++) begin
            wr(32'h204 + 4 * (s % 2), $urandom);
            upto(s);
            rdc(32'h204, pv(s < e ? 1 : 2, 1, s, s < e ? s : e));
            rdc(32'h208, pv(s < e ? 1 : 2, 0, 0, 0));
        end
        chk(32'(shutdownLine), 32'h1);
        launch(0, 0);
        rdc(32'h204, 32'h0);
        rdc(32'h208, 32'h0);
        chk(32'(shutdownLine), 32'h0);
        wr(32'h240, 32'h2);
        launch(4, 2);
        upto(243);
        rdc(32'h204, pv(2, 1, 3, 2));
        upto(245);
        rdc(32'h204, pv(2, 1, 1, 2));
        chk(32'(shutdownLine), 32'h1);
        upto(420);
        chk(32'(shutdownLine), 32'h0);
        wr(32'h240, 32'h3ff);
        launch(2, 0);
        upto(1025);
        rdc(32'h204, pv(1, 1, 1, 1));
        xfer(1'b0, 3'h1, 32'h204, 32'h0);
        chk(r, 32'h0);
        e = 32'h300 + 4 * ($urandom % 64);
        wr(e, $urandom);
        rdc(e, 32'h0);
        for (int i = 0; i < 3; i++) begin
            launch(2, i == 2 ? 2 : 1);
            {calibrationFaultAlert, timeoutExitAlert, thermalExitAlert} <= 3'h1 << i;
            @(posedge clk);
            {calibrationFaultAlert, timeoutExitAlert, thermalExitAlert} <= 3'h0;
            upto(1);
            rdc(32'h208, pv(3, 0, 0, 0));
            rdc(32'h204, pv(3, 1, 1, i == 2 ? 32'h3ff : 0));
            chk(32'(shutdownLine), 32'(i == 2));
        end
        sw = 14'($urandom) | 14'h1;
        wr(32'h244, {18'h0, sw});
        for (int k = 0; k < 3; k++) begin
            bl = k == 2 ? sw : 14'($urandom);
            f = 14'($urandom);
            launch(4, 0);
            uvCheckEnable <= k > 0;
            cellBelowThreshold <= bl;
            cellCheckUnsupported <= f;
            repeat (3) @(posedge clk);
            cellBelowThreshold <= 14'h0;
            cellCheckUnsupported <= 14'h0;
            f = k == 0 ? 14'h0 : (bl | f) & sw;
            upto(0);
            rdc(32'h208, {16'h0, f == sw ? 2'h2 : 2'h1, f});
        end
        launch(4, 0);
        rdc(32'h208, pv(1, 0, 0, 0));
        launch(2, 3);
        repeat (8) @(posedge clk);
        do_reset();
        rdc(32'h204, 32'h0);
        chk(32'(shutdownLine), 32'h0);
        conclude();
    end
endmodule
